// [hw/product_term_macrocell_array.sv]
/*
  Embedded macro block in product-term mode: 16 macrocells fed by 32 routing
  inputs and 9 feedback lines, two block-wide clocks with enables, two
  invertible clears, chip-wide reset, and a Wishbone slave holding the term
  masks and configuration. Assumes all pins are synchronous to ref_clk; the
  block clocks are sampled as levels and turned into enable pulses.
*/
`timescale 1ns/1ps
`include "ptm_defs.svh"

module product_term_macrocell_array #(
  parameter int CELLS            = 16,
  parameter int FEEDBACK         = `PTM_FEEDBACK_COUNT,
  parameter int DEDICATED_CLOCKS = `PTM_DEDICATED_CLOCKS,
  parameter int GLOBALS          = 4
) (
  input  wire logic                                ref_clk,
  input  wire logic                                rstn,
  // classic wishbone slave
  input  wire logic                                wb_cyc,
  input  wire logic                                wb_stb,
  input  wire logic                                wb_we,
  input  wire logic [11:0]                         wb_adr,
  input  wire logic [3:0]                          wb_sel,
  input  wire logic [31:0]                         wb_dat_w,
  output logic      [31:0]                         wb_dat_r,
  output logic                                     wb_ack,
  // logic sources
  input  wire logic [`PTM_LOGIC_INPUTS-1:0]        logic_in,
  input  wire logic [DEDICATED_CLOCKS-1:0]         dedicated_clock,
  input  wire logic [GLOBALS-1:0]                  global_signal,
  input  wire logic                                local_clock_one,
  input  wire logic                                local_clock_two,
  input  wire logic                                block_clock_one_enable,
  input  wire logic                                block_clock_two_enable,
  input  wire logic                                local_clear_one,
  input  wire logic                                local_clear_two,
  input  wire logic                                chip_wide_reset_n,
  // macrocell results
  output logic      [CELLS-1:0]                    macro_out
);

  localparam int TERMS    = 2 * CELLS;
  localparam int TERM_W   = `PTM_LOGIC_INPUTS + FEEDBACK;
  localparam int TERM_IDX = $clog2(TERMS);
  localparam int CELL_IDX = $clog2(CELLS);

  // ============================================================
  // configuration storage
  ptm_pkg::block_ctrl_type ctrl_reg;
  ptm_pkg::cell_cfg_type   cell_cfg_reg [CELLS];
  logic [31:0]             pt_true_reg  [TERMS];
  logic [31:0]             pt_comp_reg  [TERMS];
  logic [31:0]             pt_fb_reg    [TERMS];

  // ============================================================
  // datapath state
  logic [CELLS-1:0]                 out_reg;
  logic [`PTM_LOGIC_INPUTS-1:0]     inputs_seen_reg;
  logic                             clk_one_prev_reg;
  logic                             clk_two_prev_reg;
  logic                             ack_reg;
  logic [31:0]                      dat_reg;

  // ============================================================
  // bus decode
  logic [11:0]          word_adr;
  logic                 req;
  logic                 wr;
  logic                 hit_ctrl;
  logic                 hit_status;
  logic                 hit_inputs;
  logic                 hit_cell;
  logic                 hit_pt;
  logic [CELL_IDX-1:0]  cell_idx;
  logic [TERM_IDX-1:0]  term_idx;
  logic [1:0]           term_word;
  logic [31:0]          lane_mask;
  logic [31:0]          rd_next;
  logic [31:0]          status_word;

  assign word_adr   = {wb_adr[11:2], 2'h0};
  assign req        = wb_cyc & wb_stb & ~ack_reg;
  assign wr         = req & wb_we;
  assign cell_idx   = word_adr[CELL_IDX+1:2];
  assign term_idx   = word_adr[TERM_IDX+3:4];
  assign term_word  = word_adr[3:2];
  assign lane_mask  = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};

  // region hits; unmapped addresses still get an ack with zero data
  assign hit_ctrl   = (word_adr == `PTM_CTRL_OFFSET);
  assign hit_status = (word_adr == `PTM_STATUS_OFFSET);
  assign hit_inputs = (word_adr == `PTM_INPUTS_OFFSET);
  assign hit_cell   = ((word_adr & `PTM_CELL_REGION_MASK) == `PTM_CELL_BASE) &&
                      (32'(word_adr[7:2]) < CELLS);
  assign hit_pt     = ((word_adr & `PTM_PT_REGION_MASK) == `PTM_PT_BASE) &&
                      (32'(word_adr[8:4]) < TERMS) &&
                      (term_word != 2'h3);

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [31:0] mask
  );
    lane_merge = (old_word & ~mask) | (new_word & mask);
  endfunction : lane_merge

  // merge at full bus width, then cut back to the field width on purpose
  logic [31:0] ctrl_merged;
  logic [31:0] cell_merged;
  assign ctrl_merged = lane_merge(32'(ctrl_reg), wb_dat_w, lane_mask);
  assign cell_merged = lane_merge(32'(cell_cfg_reg[cell_idx]), wb_dat_w, lane_mask);

  // ============================================================
  // block clock and clear sourcing
  logic clk_one_level;
  logic clk_two_level;
  logic step_one;
  logic step_two;
  logic clear_one_src;
  logic clear_two_src;
  logic clear_one;
  logic clear_two;
  logic chip_reset;

  // src 0..3 dedicated pin, 4..6 global signal, 7 local routing
  assign clk_one_level = ctrl_reg.clk_one_src[2] ?
                         ((ctrl_reg.clk_one_src[1:0] == 2'h3) ? local_clock_one :
                          global_signal[ctrl_reg.clk_one_src[1:0]]) :
                         dedicated_clock[ctrl_reg.clk_one_src[1:0]];
  assign clk_two_level = ctrl_reg.clk_two_src[2] ?
                         ((ctrl_reg.clk_two_src[1:0] == 2'h3) ? local_clock_two :
                          global_signal[ctrl_reg.clk_two_src[1:0]]) :
                         dedicated_clock[ctrl_reg.clk_two_src[1:0]];

  // edge per clock, so one block can run rising and falling cells at once
  assign step_one = (ctrl_reg.clk_one_fall ? (clk_one_prev_reg & ~clk_one_level) :
                     (~clk_one_prev_reg & clk_one_level)) & block_clock_one_enable;
  assign step_two = (ctrl_reg.clk_two_fall ? (clk_two_prev_reg & ~clk_two_level) :
                     (~clk_two_prev_reg & clk_two_level)) & block_clock_two_enable;

  // clear src 0..2 global signal, 3 local routing
  assign clear_one_src = (ctrl_reg.clr_one_src == 2'h3) ? local_clear_one :
                         global_signal[ctrl_reg.clr_one_src];
  assign clear_two_src = (ctrl_reg.clr_two_src == 2'h3) ? local_clear_two :
                         global_signal[ctrl_reg.clr_two_src];
  assign clear_one     = clear_one_src ^ ctrl_reg.clr_one_inv;
  assign clear_two     = clear_two_src ^ ctrl_reg.clr_two_inv;
  assign chip_reset    = ~chip_wide_reset_n;

  // ============================================================
  // product-term array
  logic [TERM_W-1:0] term_in;
  logic [TERMS-1:0]  pt;

  // feedback uses the registered outputs, which keeps the array loop-free
  assign term_in = {out_reg[FEEDBACK-1:0], logic_in};

  genvar gp;
  generate
    for (gp = 0; gp < TERMS; gp++) begin : g_term
      logic [TERM_W-1:0] want_high;
      logic [TERM_W-1:0] want_low;
      assign want_high = {pt_fb_reg[gp][`PTM_FB_TRUE_LSB +: FEEDBACK], pt_true_reg[gp]};
      assign want_low  = {pt_fb_reg[gp][`PTM_FB_COMP_LSB +: FEEDBACK], pt_comp_reg[gp]};
      // an empty term (no literal picked) evaluates true
      assign pt[gp] = &((~want_high | term_in) & (~want_low | ~term_in));
    end
  endgenerate

  // ============================================================
  // macrocells and expander chain
  logic [CELLS:0]   chain;
  logic [CELLS-1:0] cell_value;

  // the first cell has nobody to borrow from; chain ripples upward
  assign chain[0] = 1'b0;

  genvar gc;
  generate
    for (gc = 0; gc < CELLS; gc++) begin : g_cell
      ptm_macrocell u_cell (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .cfg        (cell_cfg_reg[gc]),
        .pt0        (pt[2*gc]),
        .pt1        (pt[2*gc+1]),
        .chain_in   (chain[gc]),
        .step_one   (step_one),
        .step_two   (step_two),
        .clear_one  (clear_one),
        .clear_two  (clear_two),
        .chip_reset (chip_reset),
        .chain_out  (chain[gc+1]),
        .cell_value (cell_value[gc])
      );
    end
  endgenerate

  // ============================================================
  // read data
  assign status_word = {13'h0000, chip_reset, clear_two, clear_one,
                        {(16-CELLS){1'b0}}, out_reg};

  always_comb begin
    rd_next = 32'h00000000;
    if (hit_ctrl) begin
      rd_next = {{(32-`PTM_CTRL_WIDTH){1'b0}}, ctrl_reg};
    end else if (hit_status) begin
      rd_next = status_word;
    end else if (hit_inputs) begin
      rd_next = inputs_seen_reg;
    end else if (hit_cell) begin
      rd_next = {{(32-`PTM_CELL_CFG_WIDTH){1'b0}}, cell_cfg_reg[cell_idx]};
    end else if (hit_pt) begin
      if (term_word == `PTM_PT_WORD_TRUE) begin
        rd_next = pt_true_reg[term_idx];
      end else if (term_word == `PTM_PT_WORD_COMP) begin
        rd_next = pt_comp_reg[term_idx];
      end else begin
        rd_next = pt_fb_reg[term_idx];
      end
    end
  end

  // ============================================================
  // bus handshake: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req;
      dat_reg <= (req & ~wb_we) ? rd_next : 32'h00000000;
    end
  end

  // control word write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `PTM_CTRL_RESET;
    end else if (wr && hit_ctrl) begin
      ctrl_reg <= ctrl_merged[`PTM_CTRL_WIDTH-1:0];
    end
  end

  // cell configuration writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CELLS; i++) begin
        cell_cfg_reg[i] <= `PTM_CELL_CFG_RESET;
      end
    end else if (wr && hit_cell) begin
      cell_cfg_reg[cell_idx] <= cell_merged[`PTM_CELL_CFG_WIDTH-1:0];
    end
  end

  // term mask writes; reset leaves every term empty
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < TERMS; i++) begin
        pt_true_reg[i] <= `PTM_MASK_RESET;
        pt_comp_reg[i] <= `PTM_MASK_RESET;
        pt_fb_reg[i]   <= `PTM_MASK_RESET;
      end
    end else if (wr && hit_pt) begin
      if (term_word == `PTM_PT_WORD_TRUE) begin
        pt_true_reg[term_idx] <= lane_merge(pt_true_reg[term_idx], wb_dat_w, lane_mask);
      end else if (term_word == `PTM_PT_WORD_COMP) begin
        pt_comp_reg[term_idx] <= lane_merge(pt_comp_reg[term_idx], wb_dat_w, lane_mask);
      end else begin
        pt_fb_reg[term_idx]   <= lane_merge(pt_fb_reg[term_idx], wb_dat_w, lane_mask);
      end
    end
  end

  // ============================================================
  // clock edge history, input snapshot and output register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_one_prev_reg <= 1'b0;
      clk_two_prev_reg <= 1'b0;
      inputs_seen_reg  <= 32'h00000000;
      out_reg          <= '0;
    end else begin
      clk_one_prev_reg <= clk_one_level;
      clk_two_prev_reg <= clk_two_level;
      inputs_seen_reg  <= logic_in;
      out_reg          <= cell_value;   // one flop of latency, even in comb mode
    end
  end

  assign wb_ack    = ack_reg;
  assign wb_dat_r  = dat_reg;
  assign macro_out = out_reg;

endmodule : product_term_macrocell_array

// [hw/ptm_defs.svh]
/*
  Register offsets, field positions, reset values and fixed counts of the
  product-term macrocell array. Assumes a 32-bit classic Wishbone slave with a
  12-bit byte address, word aligned.
*/
// Functional notes
// - In product-term use the block holds sixteen macrocells, each made of two product terms and one register.
// - The product terms take their sources from 32 logic inputs coming off local routing.
// - Nine macrocell outputs come back into the block and can be used as product-term inputs.
// - Each macrocell is set on its own to registered or combinatorial, the latter bypassing the register.
// - Each product term is steered either into its own macrocell's OR and XOR gates or out as a parallel expander.
// - One product term of each macrocell can be inverted before it is combined.
// - Each macrocell register can act as a D, T, JK or SR flip-flop.
// - Each register uses one of two block-wide clocks, each picked from dedicated clocks, global signals or local routing.
// - Each block-wide clock has its own enable from local routing, and a macrocell on that clock obeys that enable.
// - Rising and falling edge clocking in one block is done by giving each block-wide clock its own edge polarity.
// - Two asynchronous clears are formed from global signals and local routing, and each register picks one or none.
// - Either block clear can be inverted inside the block.
// - A macrocell OR gate can take up to 32 product terms, its own two plus up to 30 borrowed expanders.
// - Borrowing runs as up to 15 chained sets of two product terms, each set adding a little delay.
// - Four dedicated clock pins are offered as block-wide clock sources.
// - The chip-wide reset clears every macrocell register and beats every other control, enables and clears included.
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH

// ============================================================
// register map (byte addresses)
`define PTM_CTRL_OFFSET        12'h000
`define PTM_STATUS_OFFSET      12'h004
`define PTM_INPUTS_OFFSET      12'h008
`define PTM_CELL_BASE          12'h100
`define PTM_CELL_REGION_MASK   12'hFC0
`define PTM_PT_BASE            12'h200
`define PTM_PT_REGION_MASK     12'hE00

// ============================================================
// product-term word selects inside one 16-byte term slot
`define PTM_PT_WORD_TRUE       2'h0
`define PTM_PT_WORD_COMP       2'h1
`define PTM_PT_WORD_FEEDBACK   2'h2

// feedback word fields
`define PTM_FB_TRUE_LSB        0
`define PTM_FB_COMP_LSB        16

// ============================================================
// field widths and positions
`define PTM_CTRL_WIDTH         14
`define PTM_CELL_CFG_WIDTH     12
`define PTM_STATUS_BLOCK_ASYNC_CLEAR_ONE_BIT    16
`define PTM_STATUS_BLOCK_ASYNC_CLEAR_TWO_BIT    17
`define PTM_STATUS_RESET_BIT   18

// ============================================================
// reset values
`define PTM_CTRL_RESET         14'h0000
`define PTM_CELL_CFG_RESET     12'h000
`define PTM_MASK_RESET         32'h00000000

// ============================================================
// fixed counts
`define PTM_LOGIC_INPUTS       32
`define PTM_FEEDBACK_COUNT     9
`define PTM_DEDICATED_CLOCKS   4

`endif

// [hw/ptm_pkg.sv]
/*
  Types of the product-term macrocell array: per-cell configuration, block
  control word and register kinds. Assumes ptm_defs.svh for widths.
*/
package ptm_pkg;

  // ============================================================
  // register behaviour of one macrocell
  typedef enum logic [1:0] {
    FF_D  = 2'h0,
    FF_T  = 2'h1,
    FF_JK = 2'h2,
    FF_SR = 2'h3
  } ff_kind_type;

  // ============================================================
  // clear selection of one macrocell
  typedef enum logic [1:0] {
    CLEAR_NONE = 2'h0,
    CLEAR_ONE  = 2'h1,
    CLEAR_TWO  = 2'h2,
    CLEAR_RSVD = 2'h3
  } clear_sel_type;

  // one cell configuration word, bits [11:0]
  typedef struct packed {
    clear_sel_type clear_sel;     // [11:10]
    logic          clock_sel;     // [9] 0 clock one, 1 clock two
    ff_kind_type   ff_kind;       // [8:7]
    logic          registered;    // [6]
    logic          xor_pol;       // [5]
    logic          pass_chain;    // [4]
    logic          take_expander; // [3]
    logic          invert_pt1;    // [2]
    logic          pt1_lend;      // [1]
    logic          pt0_lend;      // [0]
  } cell_cfg_type;

  // block control word, bits [13:0]
  typedef struct packed {
    logic       clk_two_fall;     // [13]
    logic [2:0] clk_two_src;      // [12:10]
    logic       clk_one_fall;     // [9]
    logic [2:0] clk_one_src;      // [8:6]
    logic       clr_two_inv;      // [5]
    logic [1:0] clr_two_src;      // [4:3]
    logic       clr_one_inv;      // [2]
    logic [1:0] clr_one_src;      // [1:0]
  } block_ctrl_type;

endpackage : ptm_pkg

// [hw/ptm_macrocell.sv]
/*
  One macrocell: product-term steering, expander chain stage, OR/XOR gate and
  programmable register. Assumes the top supplies one-cycle clock enables and
  synchronous clear levels, all on ref_clk.
*/
`timescale 1ns/1ps
`include "ptm_defs.svh"

module ptm_macrocell (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire ptm_pkg::cell_cfg_type cfg,
  input  wire logic                  pt0,
  input  wire logic                  pt1,
  input  wire logic                  chain_in,
  input  wire logic                  step_one,
  input  wire logic                  step_two,
  input  wire logic                  clear_one,
  input  wire logic                  clear_two,
  input  wire logic                  chip_reset,
  output logic                       chain_out,
  output logic                       cell_value
);

  logic pt1_pol;
  logic prim0;
  logic prim1;
  logic borrowed;
  logic lend;
  logic pair_mode;
  logic first_sum;
  logic logic_val;
  logic second_in;
  logic step;
  logic clr;
  logic q_reg;
  logic q_next;

  // ============================================================
  // term steering and expander chain
  assign pt1_pol   = pt1 ^ cfg.invert_pt1;
  assign prim0     = pt0 & ~cfg.pt0_lend;
  assign prim1     = pt1_pol & ~cfg.pt1_lend;
  assign lend      = (pt0 & cfg.pt0_lend) | (pt1_pol & cfg.pt1_lend);
  // each stage adds its set of two onto what it passes on
  assign chain_out = lend | (cfg.pass_chain & chain_in);
  assign borrowed  = cfg.take_expander & chain_in;

  // jk and sr use the second own term as k or r input
  assign pair_mode = (cfg.ff_kind == ptm_pkg::FF_JK) || (cfg.ff_kind == ptm_pkg::FF_SR);
  assign first_sum = prim0 | borrowed | (prim1 & ~pair_mode);
  assign second_in = prim1 & pair_mode;
  assign logic_val = first_sum ^ cfg.xor_pol;

  // ============================================================
  // clock and clear selection
  assign step = cfg.clock_sel ? step_two : step_one;
  assign clr  = ((cfg.clear_sel == ptm_pkg::CLEAR_ONE) & clear_one) |
                ((cfg.clear_sel == ptm_pkg::CLEAR_TWO) & clear_two);

  // next state per register kind
  always_comb begin
    case (cfg.ff_kind)
      ptm_pkg::FF_D:  q_next = logic_val;
      ptm_pkg::FF_T:  q_next = q_reg ^ logic_val;
      ptm_pkg::FF_JK: q_next = (logic_val & ~q_reg) | (~second_in & q_reg);
      default:        q_next = logic_val | (~second_in & q_reg);   // set wins
    endcase
  end

  // chip reset first, then the clear, then the enabled edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_reg <= 1'b0;
    end else if (chip_reset) begin
      q_reg <= 1'b0;
    end else if (clr) begin
      q_reg <= 1'b0;
    end else if (step) begin
      q_reg <= q_next;
    end
  end

  assign cell_value = cfg.registered ? q_reg : logic_val;

endmodule : ptm_macrocell

// [bench/ptm_monitor.sv]
/* checker on the array ports: bus handshake and status mirrors.
   assumes one clock domain, ref_clk with async rstn. */
`timescale 1ns/1ps
module ptm_monitor #(
  parameter int CELLS = 16
) (
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire logic             wb_cyc,
  input wire logic             wb_stb,
  input wire logic             wb_we,
  input wire logic [11:0]      wb_adr,
  input wire logic [31:0]      wb_dat_r,
  input wire logic             wb_ack,
  input wire logic [31:0]      logic_in,
  input wire logic             chip_wide_reset_n,
  input wire logic [CELLS-1:0] macro_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // bus handshake
  wire rd_req = wb_cyc && wb_stb && !wb_we;
  property p_ack_once; wb_ack |=> !wb_ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_resp; wb_cyc && wb_stb && !wb_ack |=> wb_ack; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_cause; wb_ack |-> $past(wb_cyc && wb_stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack with no request");
  property p_dat_idle; !wb_ack |-> wb_dat_r == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_unmapped; wb_ack && $past(rd_req && wb_adr == 12'h00C) |-> wb_dat_r == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ==========================================================
  // status mirrors; the cell mirror is only judged while the source held still
  property p_mirror; wb_ack && $past(rd_req && wb_adr == 12'h004)
    && $past(macro_out) == $past(macro_out, 2) |-> wb_dat_r[15:0] == $past(macro_out);
  endproperty
  a_mirror: assert property (p_mirror) else $error("status cells wrong");
  property p_inputs; wb_ack && $past(rd_req && wb_adr == 12'h008)
    |-> wb_dat_r == $past(logic_in, 2);
  endproperty
  a_inputs: assert property (p_inputs) else $error("input mirror wrong");
  property p_reset_flag; wb_ack && $past(rd_req && wb_adr == 12'h004)
    |-> wb_dat_r[18] == !$past(chip_wide_reset_n);
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset flag low");
  c_write: cover property (wb_ack && $past(wb_we));
  c_chip_reset: cover property (!chip_wide_reset_n ##1 !chip_wide_reset_n);
  c_cell_rise: cover property ($rose(macro_out[0]));
endmodule : ptm_monitor

bind product_term_macrocell_array ptm_monitor #(.CELLS(CELLS)) mon (
  .ref_clk(ref_clk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
  .wb_adr(wb_adr), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .logic_in(logic_in),
  .chip_wide_reset_n(chip_wide_reset_n), .macro_out(macro_out));

// [bench/ptm_partner.sv]
/* adjacent logic elements: routing inputs and a local clock.
   assumes the bench asks for clock pulses with tick on ref_clk. */
`timescale 1ns/1ps
module ptm_partner (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        tick,
  input  wire logic [31:0] pattern,
  output logic      [31:0] logic_in,
  output logic             local_clock
);
  logic [1:0] cnt_reg;
  // ==========================================================
  // clock stands low between pulses, high two cycles per tick
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= 2'h0;
      logic_in <= 32'h0;
    end else begin
      logic_in <= pattern;
      cnt_reg  <= tick ? 2'h3 : cnt_reg - {1'b0, |cnt_reg};
    end
  end
  assign local_clock = cnt_reg[1];
endmodule : ptm_partner

// [bench/product_term_macrocell_array_tb_top.sv]
/* self-checking bench of the array: bus, terms, expanders, registers.
   assumes ptm_partner and ptm_monitor compiled alongside the design. */
`timescale 1ns/1ps
module product_term_macrocell_array_tb_top;
  logic        ref_clk = 1'b0, rstn = 1'b0, tick = 1'b0, en = 1'b0, clr = 1'b0;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, crst_n = 1'b1;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0]  wb_sel = 4'hF;
  logic [31:0] wb_dat_w = 32'h0, pattern = 32'h0, wb_dat_r, logic_in, rd;
  logic        wb_ack, lclk;
  logic [15:0] macro_out;
  int          n_mismatch = 0, check_count = 0, cyc_cnt = 0;
  logic [11:0] ta [6] = '{12'h210, 12'h214, 12'h200, 12'h230, 12'h234, 12'h228};
  always #2 ref_clk = ~ref_clk;
  ptm_partner lep (.ref_clk, .rstn, .tick, .pattern, .logic_in, .local_clock(lclk));
  product_term_macrocell_array uut (.ref_clk, .rstn, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .logic_in, .dedicated_clock({lclk, 3'h0}),
    .global_signal(4'h0), .local_clock_one(lclk), .local_clock_two(lclk),
    .block_clock_one_enable(en), .block_clock_two_enable(1'b0), .local_clear_one(clr),
    .local_clear_two(clr), .chip_wide_reset_n(crst_n), .macro_out);
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do @(posedge ref_clk); while (wb_ack !== 1'b1 && ++n < 20);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0, "no ack");
  endtask : wb
  task automatic pulse();
    @(posedge ref_clk) tick <= 1'b1;
    @(posedge ref_clk) tick <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : pulse
  task automatic mo(input logic [15:0] e, input string s);
    repeat (6) @(posedge ref_clk);
    chk({16'h0, macro_out}, {16'h0, e}, s);
  endtask : mo
  // ==========================================================
  // scenarios
  task automatic t_bus();
    wb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0, "ctrl reset");
    wb(1'b0, 12'h100, 32'h0); chk(rd, 32'h0, "cell cfg reset");
    wb(1'b1, 12'h00C, 32'hFFFFFFFF);
    wb(1'b0, 12'h00C, 32'h0); chk(rd, 32'h0, "unmapped read");
    $display("test bus done");
  endtask : t_bus
  task automatic t_terms();
    foreach (ta[i]) wb(1'b1, ta[i], 32'h1);
    pattern <= 32'h1; mo(16'hFFFF, "term on input");
    pattern <= 32'h5A5AA5A4; mo(16'hFFFC, "term off");
    wb(1'b0, 12'h008, 32'h0); chk(rd, 32'h5A5AA5A4, "inputs");
    wb(1'b0, 12'h004, 32'h0); chk(rd, 32'h0000FFFC, "status");
    wb(1'b1, 12'h100, 32'h4); mo(16'hFFFF, "invert term");
    pattern <= 32'h1;
    wb(1'b1, 12'h100, 32'h1); mo(16'hFFFC, "lend term");
    wb(1'b1, 12'h104, 32'h8); mo(16'hFFFE, "borrow term");
    wb(1'b1, 12'h100, 32'h0);
    wb(1'b1, 12'h104, 32'h0);
    $display("test terms done");
  endtask : t_terms
  task automatic t_reg();
    wb(1'b1, 12'h000, 32'h1C3);
    wb(1'b1, 12'h100, 32'h440); mo(16'hFFFC, "reg starts zero");
    pulse(); mo(16'hFFFC, "enable low");
    en <= 1'b1; pulse(); mo(16'hFFFF, "d load");
    clr <= 1'b1; pulse(); mo(16'hFFFC, "clear");
    clr <= 1'b0; mo(16'hFFFC, "clear released");
    pulse(); mo(16'hFFFF, "resume");
    wb(1'b1, 12'h000, 32'h1C7); mo(16'hFFFC, "clear inverted");
    wb(1'b1, 12'h000, 32'h3C3); pulse(); mo(16'hFFFF, "falling edge");
    crst_n <= 1'b0; pulse(); mo(16'hFFFC, "chip reset");
    wb(1'b0, 12'h004, 32'h0); chk({31'h0, rd[18]}, 32'h1, "reset flag");
    crst_n <= 1'b1;
    wb(1'b1, 12'h100, 32'h4C0); pulse(); mo(16'hFFFF, "t toggle up");
    pulse(); mo(16'hFFFC, "t toggle down");
    wb(1'b1, 12'h000, 32'hD8);
    wb(1'b1, 12'h100, 32'h8C0); pulse(); mo(16'hFFFF, "dedicated clock");
    clr <= 1'b1; pulse(); mo(16'hFFFC, "clear two");
    clr <= 1'b0; wb(1'b1, 12'h100, 32'h940); pulse(); mo(16'hFFFF, "jk set");
    $display("test registers done");
  endtask : t_reg
  // ==========================================================
  // verdict and hang guard
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    chk({16'h0, macro_out}, 32'h0, "cells in reset");
    rstn <= 1'b1;
    mo(16'hFFFF, "cells after reset");
    t_bus();
    t_terms();
    t_reg();
    print_verdict();
  end
endmodule : product_term_macrocell_array_tb_top
